// file: core/async_serial_pkg.sv
// Function
// - Start bit then data, LSB first, duplex
// - Baud source may be external clock pin
// - Data write transmits; 7-bit sends bits 0-6
// - A data write starts transmission; a mode write enabling transmit also starts it if data was queued while off
// - Transmit register write-only, FFH, shares address
// - Shifter copies complete character to buffer
// - 7-bit receive leaves buffer bit 7 zero
// - Receive buffer read-only, FFH, writes transmit
// - Frame adds start, parity, stop bits
// - Enable bits 7,6 select operation mode
// - Parity field: none, zero, odd, even
// - Length bit: 7 or 8 data bits
// - Stop bit: one or two transmitted
// - Receiver checks only one stop bit
// - Suppress bit blocks errored receive pulse
// - Infrared select bit is stored only; no logic uses it
// - Odd or even parity mismatch sets flag; status read clears to 00H
// - Missing stop bit sets framing flag
// - Unread buffer on completion sets overrun
// - Overrun repeats until buffer is read
// - Rate is clock over 2^(n+1)(k+16)
// - Source 0 external, else clock/2..128
package async_serial_pkg;

    localparam logic [15:0] ADDR_MODE       = 16'hffa0;
    localparam logic [15:0] ADDR_STATUS     = 16'hffa1;
    localparam logic [15:0] ADDR_BAUD       = 16'hffa2;
    localparam logic [15:0] ADDR_DATA       = 16'hff18;

    localparam logic [7:0]  MODE_RESET      = 8'h00;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam logic [7:0]  BAUD_RESET      = 8'h00;
    localparam logic [7:0]  TX_DATA_RESET   = 8'hff;
    localparam logic [7:0]  RX_BUF_RESET    = 8'hff;
    localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

    localparam logic [1:0]  PARITY_NONE     = 2'h0;
    localparam logic [1:0]  PARITY_ZERO     = 2'h1;
    localparam logic [1:0]  PARITY_ODD      = 2'h2;
    localparam logic [1:0]  PARITY_EVEN     = 2'h3;

    localparam logic [2:0]  SRC_EXTERNAL    = 3'h0;
    localparam logic [4:0]  DIV_BASE        = 5'h10;
    localparam int          PRESCALE_WIDTH  = 7;

    localparam int          DATA_WIDTH      = 8;
    localparam int          TX_FIFO_DEPTH   = 32;
    localparam logic [2:0]  LAST_BIT_7      = 3'h6;
    localparam logic [2:0]  LAST_BIT_8      = 3'h7;
    localparam int          MSB_INDEX       = 7;

    typedef struct packed {
        logic       transmitEnableBit;
        logic       receiveEnableBit;
        logic       paritySelectHigh;
        logic       paritySelectLow;
        logic       charLengthBit;
        logic       stopLengthBit;
        logic       errorIrqSuppress;
        logic       infraredModeSelect;
    } mode_s;

    typedef struct packed {
        logic [4:0] zeros;
        logic       parityErrorFlag;
        logic       framingErrorFlag;
        logic       overrunFlag;
    } status_s;

    typedef struct packed {
        logic       zero;
        logic [2:0] sourceSelect;
        logic [3:0] divideSelect;
    } baud_s;

    typedef enum logic [2:0] {
        TX_IDLE   = 3'b000,
        TX_START  = 3'b001,
        TX_DATA   = 3'b010,
        TX_PARITY = 3'b011,
        TX_STOP   = 3'b100
    } tx_state_e;

    typedef enum logic [2:0] {
        RX_IDLE   = 3'b000,
        RX_START  = 3'b001,
        RX_DATA   = 3'b010,
        RX_PARITY = 3'b011,
        RX_STOP   = 3'b100
    } rx_state_e;

endpackage

// file: core/sync_fifo.sv
`timescale 1ns/100ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0]      wrPtr_reg;
    logic [PW:0]      rdPtr_reg;
    logic             push;
    logic             pop;

    assign inReady  = (wrPtr_reg[PW] == rdPtr_reg[PW]) || (wrPtr_reg[PW-1:0] != rdPtr_reg[PW-1:0]);
    assign outValid = (wrPtr_reg != rdPtr_reg);
    assign outData  = store[rdPtr_reg[PW-1:0]];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            store[wrPtr_reg[PW-1:0]] <= inData;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
        end
    end
endmodule // sync_fifo

// file: core/async_serial_port_core.sv
`timescale 1ns/100ps
module async_serial_port_core
    import async_serial_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [15:0] cpuAddr,
    input  wire logic        cpuWrite,
    input  wire logic        cpuRead,
    input  wire logic [7:0]  cpuWdata,
    output logic      [7:0]  cpuRdata,
    output logic             txReady,
    input  wire logic        serialInPin,
    input  wire logic        externalBaudClockPin,
    output logic             serialOutPin,
    output logic             serialOutOe_n,
    output logic             receiveDoneIrq,
    output logic             transmitDoneIrq
);

    mode_s            serialModeControl_reg;
    status_s          receiveErrorStatus_reg;
    baud_s            baudDividerControl_reg;
    logic [7:0]       transmitData_reg;
    logic [7:0]       receiveDataBuffer_reg;
    logic [7:0]       cpuRdata_reg;
    logic             rxUnread_reg;

    logic             wrMode;
    logic             wrBaud;
    logic             wrData;
    logic             rdStatus;
    logic             rdRxBuf;
    logic [1:0]       paritySel;
    logic             anyEnable;

    // Bus decode
    assign wrMode    = cpuWrite && (cpuAddr == ADDR_MODE);
    assign wrBaud    = cpuWrite && (cpuAddr == ADDR_BAUD);
    assign wrData    = cpuWrite && (cpuAddr == ADDR_DATA);
    assign rdStatus  = cpuRead && (cpuAddr == ADDR_STATUS);
    assign rdRxBuf   = cpuRead && (cpuAddr == ADDR_DATA);
    assign paritySel = {serialModeControl_reg.paritySelectHigh, serialModeControl_reg.paritySelectLow};
    assign anyEnable = serialModeControl_reg.transmitEnableBit || serialModeControl_reg.receiveEnableBit;

    function automatic logic parityOf(input logic [7:0] data, input logic [1:0] sel);
        logic p;
        p = 1'b0;
        if (sel == PARITY_ODD) begin
            p = ~^data;
        end else if (sel == PARITY_EVEN) begin
            p = ^data;
        end
        return p;
    endfunction

    function automatic logic [6:0] sourceMask(input logic [2:0] n);
        logic [6:0] m;
        m = 7'h00;
        for (int i = 0; i < PRESCALE_WIDTH; i++) begin
            if (i < int'(n)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Register writes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            serialModeControl_reg  <= MODE_RESET;
            baudDividerControl_reg <= BAUD_RESET;
            transmitData_reg       <= TX_DATA_RESET;
        end else begin
            if (wrMode) begin
                serialModeControl_reg <= cpuWdata;
            end
            if (wrBaud) begin
                baudDividerControl_reg <= {1'b0, cpuWdata[6:0]};
            end
            if (wrData) begin
                transmitData_reg <= cpuWdata;
            end
        end
    end

    // Register reads, one cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cpuRdata_reg <= UNMAPPED_READ;
        end else if (cpuRead) begin
            if (cpuAddr == ADDR_MODE) begin
                cpuRdata_reg <= serialModeControl_reg;
            end else if (cpuAddr == ADDR_STATUS) begin
                cpuRdata_reg <= receiveErrorStatus_reg;
            end else if (cpuAddr == ADDR_BAUD) begin
                cpuRdata_reg <= baudDividerControl_reg;
            end else if (cpuAddr == ADDR_DATA) begin
                cpuRdata_reg <= receiveDataBuffer_reg;
            end else begin
                cpuRdata_reg <= UNMAPPED_READ;
            end
        end
    end
    assign cpuRdata = cpuRdata_reg;

    // Baud generator: prescaler, then divide by k+16 into half-bit ticks
    logic [6:0]       prescale_reg;
    logic             extClkLast_reg;
    logic [4:0]       divCount_reg;
    logic             sourceTick;
    logic             halfTick;
    logic             bitPhase_reg;
    logic             bitTick;
    logic [4:0]       divLast;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prescale_reg   <= '0;
            extClkLast_reg <= 1'b0;
        end else begin
            prescale_reg   <= anyEnable ? prescale_reg + 1'b1 : '0;
            extClkLast_reg <= externalBaudClockPin;
        end
    end

    always_comb begin
        if (baudDividerControl_reg.sourceSelect == SRC_EXTERNAL) begin
            sourceTick = externalBaudClockPin && !extClkLast_reg;
        end else begin
            sourceTick = (prescale_reg & sourceMask(baudDividerControl_reg.sourceSelect))
                         == sourceMask(baudDividerControl_reg.sourceSelect);
        end
    end

    assign divLast  = DIV_BASE + {1'b0, baudDividerControl_reg.divideSelect} - 5'h01;
    assign halfTick = anyEnable && sourceTick && (divCount_reg == divLast);
    assign bitTick  = halfTick && bitPhase_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            divCount_reg <= '0;
            bitPhase_reg <= 1'b0;
        end else if (!anyEnable) begin
            divCount_reg <= '0;
            bitPhase_reg <= 1'b0;
        end else if (sourceTick) begin
            divCount_reg <= (divCount_reg == divLast) ? 5'h00 : divCount_reg + 5'h01;
            if (divCount_reg == divLast) begin
                bitPhase_reg <= !bitPhase_reg;
            end
        end
    end

    // Transmit path
    tx_state_e        txState_reg;
    logic [7:0]       txShift_reg;
    logic [2:0]       txBit_reg;
    logic [1:0]       txStopLeft_reg;
    logic             serialOut_reg;
    logic             txDone_reg;
    logic             fifoValid;
    logic [7:0]       fifoData;
    logic             fifoPop;
    logic [2:0]       txLastBit;

    assign fifoPop   = (txState_reg == TX_IDLE) && fifoValid && serialModeControl_reg.transmitEnableBit;
    assign txLastBit = serialModeControl_reg.charLengthBit ? LAST_BIT_8 : LAST_BIT_7;

    sync_fifo #(
        .WIDTH (DATA_WIDTH),
        .DEPTH (TX_FIFO_DEPTH)
    ) txFifo (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .inValid  (wrData),
        .inReady  (txReady),
        .inData   (cpuWdata),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoData)
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            txState_reg   <= TX_IDLE;
            txShift_reg   <= TX_DATA_RESET;
            txBit_reg     <= '0;
            txStopLeft_reg <= '0;
            serialOut_reg <= 1'b1;
            txDone_reg    <= 1'b0;
        end else begin
            txDone_reg <= 1'b0;
            if (!serialModeControl_reg.transmitEnableBit) begin
                txState_reg   <= TX_IDLE;
                serialOut_reg <= 1'b1;
            end else begin
                case (txState_reg)
                    TX_IDLE: begin
                        serialOut_reg <= 1'b1;
                        if (fifoPop) begin
                            txShift_reg <= serialModeControl_reg.charLengthBit ? fifoData
                                                                               : {1'b0, fifoData[6:0]};
                            txState_reg <= TX_START;
                        end
                    end
                    TX_START: begin
                        if (bitTick) begin
                            serialOut_reg <= 1'b0;
                            txBit_reg     <= '0;
                            txState_reg   <= TX_DATA;
                        end
                    end
                    TX_DATA: begin
                        if (bitTick) begin
                            serialOut_reg <= txShift_reg[txBit_reg];
                            if (txBit_reg == txLastBit) begin
                                // Without parity this state sends the first stop bit instead
                                txState_reg <= TX_PARITY;
                            end
                            txBit_reg <= txBit_reg + 3'h1;
                        end
                    end
                    TX_PARITY: begin
                        if (bitTick) begin
                            if (paritySel == PARITY_NONE) begin
                                serialOut_reg  <= 1'b1;
                                txStopLeft_reg <= {1'b0, serialModeControl_reg.stopLengthBit};
                            end else begin
                                serialOut_reg  <= parityOf(txShift_reg, paritySel);
                                txStopLeft_reg <= {1'b0, serialModeControl_reg.stopLengthBit} + 2'h1;
                            end
                            txState_reg <= TX_STOP;
                        end
                    end
                    TX_STOP: begin
                        if (bitTick) begin
                            serialOut_reg <= 1'b1;
                            if (txStopLeft_reg != 2'h0) begin
                                txStopLeft_reg <= txStopLeft_reg - 2'h1;
                            end else begin
                                txState_reg <= TX_IDLE;
                                txDone_reg  <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        txState_reg <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    assign serialOutPin    = serialOut_reg;
    assign serialOutOe_n   = !serialModeControl_reg.transmitEnableBit;
    assign transmitDoneIrq = txDone_reg;

    // Receive path
    rx_state_e        rxState_reg;
    logic [7:0]       rxShifter_reg;
    logic [2:0]       rxBit_reg;
    logic             rxHalf_reg;
    logic             rxIn_reg;
    logic             rxParity_reg;
    logic             rxDone_reg;
    logic             rxSample;
    logic             rxComplete;
    logic             rxFrameErr;
    logic             rxParityErr;
    logic             rxOverrun;
    logic             rxAnyErr;

    assign rxSample    = halfTick && rxHalf_reg;
    assign rxComplete  = (rxState_reg == RX_STOP) && rxSample;
    assign rxFrameErr  = !rxIn_reg;
    assign rxParityErr = (paritySel == PARITY_ODD || paritySel == PARITY_EVEN)
                         && (rxParity_reg != parityOf(rxShifter_reg, paritySel));
    assign rxOverrun   = rxUnread_reg && !rdRxBuf;
    assign rxAnyErr    = rxFrameErr || rxParityErr || rxOverrun;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rxIn_reg      <= 1'b1;
            rxState_reg   <= RX_IDLE;
            rxShifter_reg <= '0;
            rxBit_reg     <= '0;
            rxHalf_reg    <= 1'b0;
            rxParity_reg  <= 1'b0;
        end else begin
            rxIn_reg <= serialInPin;
            if (!serialModeControl_reg.receiveEnableBit) begin
                rxState_reg <= RX_IDLE;
            end else begin
                if (halfTick) begin
                    rxHalf_reg <= !rxHalf_reg;
                end
                case (rxState_reg)
                    RX_IDLE: begin
                        rxHalf_reg <= 1'b0;
                        if (!rxIn_reg) begin
                            rxState_reg <= RX_START;
                        end
                    end
                    RX_START: begin
                        if (halfTick) begin
                            rxHalf_reg    <= 1'b0;
                            rxBit_reg     <= '0;
                            rxShifter_reg <= '0;
                            rxState_reg   <= rxIn_reg ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (rxSample) begin
                            rxShifter_reg[rxBit_reg] <= rxIn_reg;
                            rxBit_reg <= rxBit_reg + 3'h1;
                            if (rxBit_reg == txLastBit) begin
                                rxState_reg <= (paritySel == PARITY_NONE) ? RX_STOP : RX_PARITY;
                            end
                        end
                    end
                    RX_PARITY: begin
                        if (rxSample) begin
                            rxParity_reg <= rxIn_reg;
                            rxState_reg  <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (rxSample) begin
                            rxState_reg <= RX_IDLE;
                        end
                    end
                    default: begin
                        rxState_reg <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // Buffer, flags and completion pulse; a completion beats a same-cycle clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            receiveDataBuffer_reg  <= RX_BUF_RESET;
            receiveErrorStatus_reg <= STATUS_RESET;
            rxUnread_reg           <= 1'b0;
            rxDone_reg             <= 1'b0;
        end else begin
            rxDone_reg <= rxComplete && !(serialModeControl_reg.errorIrqSuppress && rxAnyErr);
            if (rxComplete) begin
                receiveDataBuffer_reg <= rxShifter_reg;
                rxUnread_reg          <= 1'b1;
            end else if (rdRxBuf) begin
                rxUnread_reg <= 1'b0;
            end
            if (rdStatus) begin
                receiveErrorStatus_reg <= STATUS_RESET;
            end
            if (rxComplete) begin
                receiveErrorStatus_reg.zeros <= '0;
                if (rxParityErr) begin
                    receiveErrorStatus_reg.parityErrorFlag <= 1'b1;
                end
                if (rxFrameErr) begin
                    receiveErrorStatus_reg.framingErrorFlag <= 1'b1;
                end
                if (rxOverrun) begin
                    receiveErrorStatus_reg.overrunFlag <= 1'b1;
                end
            end
        end
    end

    assign receiveDoneIrq = rxDone_reg;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_tx_idle_high: assert property ((txState_reg == TX_IDLE) |-> serialOutPin)
        else $error("line not idle high while transmitter idle");
    a_start_bit_low: assert property ((txState_reg == TX_START) && bitTick |=> !serialOutPin)
        else $error("start bit not low");
    a_write_starts_tx: assert property (wrData && txReady && !fifoValid && (txState_reg == TX_IDLE)
        && serialModeControl_reg.transmitEnableBit && !wrMode |-> ##2 (txState_reg == TX_START))
        else $error("data write did not start transmission");
    a_rx_msb_zero: assert property (rxComplete && !serialModeControl_reg.charLengthBit
        |=> !receiveDataBuffer_reg[MSB_INDEX])
        else $error("bit 7 set in 7-bit receive");
    a_overrun_repeat: assert property (rxComplete && rxUnread_reg && !rdRxBuf
        |=> receiveErrorStatus_reg.overrunFlag && rxUnread_reg)
        else $error("overrun not flagged");
    a_framing_flag: assert property (rxComplete && !rxIn_reg |=> receiveErrorStatus_reg.framingErrorFlag)
        else $error("framing error not flagged");
    a_zero_parity_quiet: assert property (rxComplete && (paritySel == PARITY_ZERO) && !rdStatus
        && !receiveErrorStatus_reg.parityErrorFlag |=> !receiveErrorStatus_reg.parityErrorFlag)
        else $error("parity error raised in zero parity mode");
    a_status_upper_zero: assert property (rdStatus |=> (cpuRdata[7:3] == 5'h00))
        else $error("status reserved bits not zero");
    a_suppress_done: assert property (rxComplete && rxAnyErr && serialModeControl_reg.errorIrqSuppress
        |=> !receiveDoneIrq)
        else $error("receive pulse raised on suppressed error");
    a_tx_off_released: assert property (!serialModeControl_reg.transmitEnableBit |-> serialOutOe_n)
        else $error("output driven while transmit disabled");

endmodule // async_serial_port_core

// file: verification/remote_station.sv
`timescale 1ns/100ps
module remote_station #(
    parameter int BIT_CLKS = 64
) (
    input  wire logic sys_clk,
    input  wire logic txLine,
    output logic      rxLine
);
    initial rxLine = 1'b1;
    // Start bit, then the frame bits LSB first, then back to idle high
    task automatic send(input logic [11:0] f, input int n);
        @(posedge sys_clk) rxLine <= 1'b0;
        for (int i = 0; i <= n; i++) begin
            repeat (BIT_CLKS) @(posedge sys_clk);
            rxLine <= (i == n) ? 1'b1 : f[i];
        end
        @(posedge sys_clk);
    endtask
    // Waits for a falling edge, then samples each bit near its middle
    task automatic capture(input int n, output logic [11:0] f, output logic ok);
        int w;
        f = '1;
        for (w = 0; w < 20000 && txLine !== 1'b0; w++) @(posedge sys_clk);
        repeat (BIT_CLKS / 2) @(posedge sys_clk);
        ok = (w < 20000) && (txLine === 1'b0);
        for (int i = 0; i < n; i++) begin
            repeat (BIT_CLKS) @(posedge sys_clk);
            f[i] = txLine;
        end
    endtask
endmodule // remote_station

// file: verification/async_serial_port_core_test.sv
`timescale 1ns/100ps
module async_serial_port_core_test import async_serial_pkg::*;;
    logic        sys_clk, rst, cpuWrite, cpuRead, txReady, serialInPin, serialOutPin, serialOutOe_n;
    logic        receiveDoneIrq, transmitDoneIrq, ok, extClk = 1'b0;
    logic [15:0] cpuAddr;
    logic [11:0] f, got;
    logic [7:0]  cpuWdata, cpuRdata, m, d;
    int          nMismatch = 0, cmpCount = 0, rxIrqs = 0, txIrqs = 0, n;
    async_serial_port_core dut (.sys_clk, .rst, .cpuAddr, .cpuWrite, .cpuRead, .cpuWdata, .cpuRdata,
        .txReady, .serialInPin, .externalBaudClockPin(extClk), .serialOutPin, .serialOutOe_n,
        .receiveDoneIrq, .transmitDoneIrq);
    // Baud code 10h gives 64 clocks a bit
    remote_station #(.BIT_CLKS(64)) remote (.sys_clk, .txLine(serialOutPin), .rxLine(serialInPin));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) rxIrqs <= rxIrqs + int'(receiveDoneIrq === 1'b1);
    always @(posedge sys_clk) txIrqs <= txIrqs + int'(transmitDoneIrq === 1'b1);
    // External baud source: a rising edge every second clock
    always @(posedge sys_clk) extClk <= ~extClk;
    task automatic finishTest();
        $display("Compares %0d, mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [11:0] a, input logic [11:0] e);
        cmpCount++;
        nMismatch += int'(a !== e);
        if (a !== e) $display("BAD %0t got %h, expected %h", $time, a, e);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk) {cpuAddr, cpuWdata, cpuWrite} <= {a, v, 1'b1};
        @(posedge sys_clk) cpuWrite <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk) {cpuAddr, cpuRead} <= {a, 1'b1};
        @(posedge sys_clk) cpuRead <= 1'b0;
        #1 chk(12'(cpuRdata), 12'(e));
    endtask
    task automatic waitFor(ref int c, input int target);
        for (int w = 0; w < 30000 && c < target; w++) @(posedge sys_clk);
        chk(12'(c >= target), 12'h1);
        if (c < target) finishTest();
    endtask
    task automatic setMode(input logic [7:0] v);
        wr(ADDR_MODE, MODE_RESET);
        wr(ADDR_MODE, v);
        rd(ADDR_MODE, v);
    endtask
    // Expected line bits after the start bit for mode m; k returns the bit count
    function automatic logic [11:0] frame(input logic [7:0] v, output int k);
        k = m[3] ? 8 : 7;
        frame = {4'hf, v} | (12'hfff << k);
        if (m[5:4] != PARITY_NONE) frame[k] = (m[5:4] == PARITY_ODD) ? ~^v : (m[5:4] == PARITY_EVEN) && ^v;
        k += 1 + int'(m[2]) + int'(m[5:4] != PARITY_NONE);
    endfunction
    initial begin
        {rst, cpuWrite, cpuRead, cpuAddr, cpuWdata} = {3'b100, 24'h0};
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        #1 chk(12'({serialOutPin, serialOutOe_n}), 12'h3);
        rd(ADDR_STATUS, STATUS_RESET);
        rd(ADDR_DATA, RX_BUF_RESET);
        rd(ADDR_BAUD, BAUD_RESET);
        rd(16'hff00, UNMAPPED_READ);
        wr(ADDR_STATUS, 8'h07);
        rd(ADDR_STATUS, STATUS_RESET);
        wr(ADDR_BAUD, 8'h10);
        // Every parity code, both lengths and both stop counts, in full duplex
        for (int p = 0; p < 4; p++) begin
            m = {2'b11, 2'(p), p[0], p[1], 2'b00};
            setMode(m);
            d = 8'hb4 | 8'(p);
            f = frame(d & {m[3], 7'h7f}, n);
            wr(ADDR_DATA, d);
            chk(12'(serialOutOe_n), 12'h0);
            fork
                remote.capture(n, got, ok);
                remote.send(f, n);
            join
            chk(12'(ok), 12'h1);
            if (ok !== 1'b1) finishTest();
            chk(got, f);
            // The done pulse must not come before the last stop bit has run out
            chk(12'(txIrqs), 12'(p));
            waitFor(txIrqs, p + 1);
            rd(ADDR_DATA, d & {m[3], 7'h7f});
            rd(ADDR_STATUS, STATUS_RESET);
            chk(12'(rxIrqs), 12'(p + 1));
        end
        // Parity error, framing error, then parity error with the pulse suppressed
        for (int e = 0; e < 3; e++) begin
            m = (e == 2) ? 8'h7a : 8'h78;
            setMode(m);
            chk(12'(serialOutOe_n), 12'h1);
            f = frame(8'h01, n);
            f[8 + e % 2] = ~f[8 + e % 2];
            remote.send(f, n);
            rd(ADDR_STATUS, (e == 1) ? 8'h02 : 8'h04);
            rd(ADDR_DATA, 8'h01);
            chk(12'(rxIrqs), 12'(5 + (e > 0)));
        end
        f = frame(8'h11, n);
        repeat (2) remote.send(f, n);
        rd(ADDR_STATUS, 8'h01);
        remote.send(f, n);
        rd(ADDR_STATUS, 8'h01);
        setMode(8'hc9);
        n = 0;
        for (int i = 0; i < 40; i++) begin
            n += int'(txReady === 1'b1);
            if (txReady === 1'b1) wr(ADDR_DATA, 8'(i));
        end
        chk(12'(txReady), 12'h0);
        chk(12'(n), 12'(TX_FIFO_DEPTH + 1));
        waitFor(txIrqs, 4 + n);
        chk(12'(txReady), 12'h1);
        // External source: 16 pin edges a half bit, so a bit is again 64 clocks
        wr(ADDR_MODE, MODE_RESET);
        wr(ADDR_BAUD, 8'h00);
        m = 8'hc8;
        setMode(m);
        f = frame(8'h5a, n);
        wr(ADDR_DATA, 8'h5a);
        fork
            remote.capture(n, got, ok);
            remote.send(f, n);
        join
        chk(12'(ok), 12'h1);
        chk(got, f);
        rd(ADDR_DATA, 8'h5a);
        finishTest();
    end
endmodule // async_serial_port_core_test
